// ==== bench/config_fuse_decoder_test.sv ====
/*
  Self-checking bench for the configuration decoder: random and table-driven words,
  clock-switch handshake, auxiliary protection, key lockout and bulk erase.
  Assumes the decoder answers one edge after each strobe.
*/
`timescale 1ns/100ps
module config_fuse_decoder_test;
  localparam int unsigned BASE = 4;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wdt_cfg_wr = 1'b0, i_rst_cfg_wr = 1'b0, i_aux_cfg_wr = 1'b0;
  logic [7:0] i_wdt_cfg_data = 8'h00, i_rst_cfg_data = 8'h00, i_aux_cfg_data = 8'h00;
  logic i_gen_code_protect_n = 1'b1, i_gen_write_protect_n = 1'b1;
  logic [1:0] i_gen_segment_key = 2'h0;
  logic i_bulk_erase = 1'b0, i_pll_switch_req = 1'b0, i_pll_locked = 1'b0;
  logic i_aux_prog_req = 1'b0;
  logic o_wdt_window_mode, o_lock_wait_enable, o_switch_waiting, o_switch_grant;
  logic [7:0] o_wdt_prescale_ratio;
  logic [15:0] o_wdt_postscale_ratio;
  logic o_por_timer_enable, o_brownout_enable, o_i2c1_use_alt, o_i2c2_use_alt;
  logic [config_fuse_pkg::POR_CYC_W-1:0] o_por_delay_cycles;
  logic o_aux_code_protected, o_aux_write_blocked, o_aux_key_lockout, o_aux_cfg_writable;
  logic o_aux_prog_accept, o_aux_prog_reject, o_aux_cfg_rejected;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 32'h44fc;
  logic [7:0] d;
  logic mis;

  config_fuse_decoder #(.POR_BASE_CYCLES(BASE)) uut (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_wdt_cfg_wr(i_wdt_cfg_wr), .i_wdt_cfg_data(i_wdt_cfg_data),
    .i_rst_cfg_wr(i_rst_cfg_wr), .i_rst_cfg_data(i_rst_cfg_data),
    .i_aux_cfg_wr(i_aux_cfg_wr), .i_aux_cfg_data(i_aux_cfg_data),
    .i_gen_code_protect_n(i_gen_code_protect_n), .i_gen_write_protect_n(i_gen_write_protect_n),
    .i_gen_segment_key(i_gen_segment_key), .i_bulk_erase(i_bulk_erase),
    .i_pll_switch_req(i_pll_switch_req), .i_pll_locked(i_pll_locked),
    .i_aux_prog_req(i_aux_prog_req), .o_wdt_window_mode(o_wdt_window_mode),
    .o_wdt_prescale_ratio(o_wdt_prescale_ratio), .o_wdt_postscale_ratio(o_wdt_postscale_ratio),
    .o_lock_wait_enable(o_lock_wait_enable), .o_switch_waiting(o_switch_waiting),
    .o_switch_grant(o_switch_grant), .o_por_timer_enable(o_por_timer_enable),
    .o_por_delay_cycles(o_por_delay_cycles), .o_brownout_enable(o_brownout_enable),
    .o_i2c1_use_alt(o_i2c1_use_alt), .o_i2c2_use_alt(o_i2c2_use_alt),
    .o_aux_code_protected(o_aux_code_protected), .o_aux_write_blocked(o_aux_write_blocked),
    .o_aux_key_lockout(o_aux_key_lockout), .o_aux_cfg_writable(o_aux_cfg_writable),
    .o_aux_prog_accept(o_aux_prog_accept), .o_aux_prog_reject(o_aux_prog_reject),
    .o_aux_cfg_rejected(o_aux_cfg_rejected)
  );

  always #2 i_ref_clk = ~i_ref_clk;

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      $display("ERROR timeout expected finish seen hang");
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // Inputs change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  function automatic logic [31:0] delay_exp(input logic [2:0] c);
    return (c == 3'h0) ? 32'h0 : (BASE << (c - 1));
  endfunction : delay_exp

  task automatic check_wdt(input logic [7:0] w);
    chk("window_mode", {31'h0, ~w[6]}, {31'h0, o_wdt_window_mode});
    chk("lock_wait", {31'h0, w[5]}, {31'h0, o_lock_wait_enable});
    chk("prescale", w[4] ? 32'h80 : 32'h20, {24'h0, o_wdt_prescale_ratio});
    chk("postscale", 32'h1 << w[3:0], {16'h0, o_wdt_postscale_ratio});
  endtask : check_wdt

  task automatic check_rst(input logic [7:0] w);
    chk("por_enable", {31'h0, w[2:0] != 3'h0}, {31'h0, o_por_timer_enable});
    chk("por_delay", delay_exp(w[2:0]), 32'(o_por_delay_cycles));
    chk("brownout", {31'h0, w[3]}, {31'h0, o_brownout_enable});
    chk("i2c1_alt", {31'h0, ~w[4]}, {31'h0, o_i2c1_use_alt});
    chk("i2c2_alt", {31'h0, ~w[5]}, {31'h0, o_i2c2_use_alt});
  endtask : check_rst

  task automatic erase;
    i_bulk_erase = 1'b1;
    step(1);
    i_bulk_erase = 1'b0;
    chk("erase_lockout", 32'h0, {31'h0, o_aux_key_lockout});
    step(1);
    chk("erase_writable", 32'h1, {31'h0, o_aux_cfg_writable});
  endtask : erase

  task automatic aux_wr(input logic [7:0] w);
    i_aux_cfg_data = w;
    i_aux_cfg_wr = 1'b1;
    step(1);
    i_aux_cfg_wr = 1'b0;
  endtask : aux_wr

  task automatic prog(input logic blocked);
    i_aux_prog_req = 1'b1;
    step(1);
    i_aux_prog_req = 1'b0;
    chk("prog_accept", {31'h0, ~blocked}, {31'h0, o_aux_prog_accept});
    chk("prog_reject", {31'h0, blocked}, {31'h0, o_aux_prog_reject});
  endtask : prog

  task automatic pll_req(input logic lw, input logic lk);
    i_wdt_cfg_data = {1'b0, 1'b1, lw, 5'h00};
    i_wdt_cfg_wr = 1'b1;
    i_pll_locked = lk;
    step(1);
    i_wdt_cfg_wr = 1'b0;
    i_pll_switch_req = 1'b1;
    step(1);
    i_pll_switch_req = 1'b0;
  endtask : pll_req

  initial begin
    step(5);
    i_reset_n = 1'b1;
    check_wdt(8'h7F);
    check_rst(8'h3F);
    step(1);
    chk("open_writable", 32'h1, {31'h0, o_aux_cfg_writable});
    for (int i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      if (i < 16) d[3:0] = i[3:0];
      i_wdt_cfg_data = d;
      i_wdt_cfg_wr = 1'b1;
      step(1);
      i_wdt_cfg_wr = 1'b0;
      check_wdt(d);
      d = 8'($random(seed));
      if (i < 8) d[2:0] = i[2:0];
      i_rst_cfg_data = d;
      i_rst_cfg_wr = 1'b1;
      step(1);
      i_rst_cfg_wr = 1'b0;
      check_rst(d);
    end
    i_rst_cfg_data = 8'h3F;
    i_rst_cfg_wr = 1'b1;
    step(1);
    i_rst_cfg_wr = 1'b0;
    check_rst(8'h3F);
    pll_req(1'b0, 1'b0);
    chk("grant_nowait", 32'h1, {31'h0, o_switch_grant});
    pll_req(1'b1, 1'b1);
    chk("grant_locked", 32'h1, {31'h0, o_switch_grant});
    pll_req(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk("held_wait", 32'h1, {31'h0, o_switch_waiting});
      chk("held_grant", 32'h0, {31'h0, o_switch_grant});
      step(1);
    end
    i_pll_locked = 1'b1;
    step(1);
    chk("late_grant", 32'h1, {31'h0, o_switch_grant});
    chk("wait_drop", 32'h0, {31'h0, o_switch_waiting});
    prog(1'b0);
    aux_wr(8'h0E);
    chk("aux_wb", 32'h1, {31'h0, o_aux_write_blocked});
    step(1);
    chk("closed", 32'h0, {31'h0, o_aux_cfg_writable});
    prog(1'b1);
    aux_wr(8'h03);
    chk("refused", 32'h1, {31'h0, o_aux_cfg_rejected});
    chk("kept", 32'h1, {31'h0, o_aux_write_blocked});
    erase();
    i_gen_code_protect_n = 1'b0;
    step(2);
    aux_wr(8'h03);
    chk("gen_refused", 32'h1, {31'h0, o_aux_cfg_rejected});
    i_gen_code_protect_n = 1'b1;
    i_gen_segment_key = 2'h1;
    step(2);
    chk("gen_key_closed", 32'h0, {31'h0, o_aux_cfg_writable});
    i_gen_segment_key = 2'h0;
    for (int i = 0; i < 16; i++) begin
      erase();
      d = {4'h0, i[3:0]};
      mis = (d[3:2] != ((d[0] & d[1]) ? 2'h0 : 2'h3));
      aux_wr(d);
      chk("lockout", {31'h0, mis}, {31'h0, o_aux_key_lockout});
      chk("aux_cp", {31'h0, ~d[1] | mis}, {31'h0, o_aux_code_protected});
      chk("aux_wb", {31'h0, ~d[0]}, {31'h0, o_aux_write_blocked});
      prog(~d[0]);
      chk("lock_held", {31'h0, mis}, {31'h0, o_aux_key_lockout});
    end
    erase();
    conclude();
  end
endmodule : config_fuse_decoder_test

// ==== common/aux_protect_if.sv ====
/*
  Carries the auxiliary word and general-segment protection to the evaluator and its verdicts back.
  Assumes purely combinational use inside one clock domain.
*/
`timescale 1ns/100ps
interface aux_protect_if;
  logic [7:0] aux_cur;
  logic [7:0] aux_next;
  logic gen_code_protect_n;
  logic gen_write_protect_n;
  logic [1:0] gen_segment_key;
  logic key_mismatch;
  logic cfg_unlocked;

  modport eval (input aux_cur, aux_next, gen_code_protect_n, gen_write_protect_n,
    gen_segment_key, output key_mismatch, cfg_unlocked);
  modport ctrl (output aux_cur, aux_next, gen_code_protect_n, gen_write_protect_n,
    gen_segment_key, input key_mismatch, cfg_unlocked);
endinterface : aux_protect_if

// ==== common/config_fuse_defines.svh ====
/*
  Offsets of fields inside the configuration words, reset values and timing figures.
  Assumes inclusion by bare name from the decoder files.
*/
// How it works
// - Window-disable field 1 runs the watchdog in non-window mode, 0 in window mode.
// - With lock-wait set, a switch to the PLL waits for a valid lock; cleared, it proceeds.
// - Prescaler select 1 gives a 1:128 ratio and 0 gives 1:32.
// - Postscaler code n gives ratio 2 to the n, from 1:1 at 0000 to 1:32,768 at 1111.
// - Reset timer code 000 disables it, codes 001 to 111 give 2 ms doubling up to 128 ms.
// - Brown-out detection is on when its enable field is 1 and off when 0.
// - A key that disagrees with the protect fields code-protects the auxiliary segment
//         until a bulk erase.
// - The auxiliary segment is code-protected when its code-protect field is 0.
// - Program writes to the auxiliary segment are refused while its write-protect field is 0.
// - The auxiliary word may change only by a bulk erase or with all protection off and both keys zero.
// - Port 2 pin field 1 selects the primary pins and 0 the alternate pins.
// - Port 1 pin field 0 selects the alternate pins and 1 the primary pins.
`ifndef CONFIG_FUSE_DEFINES_SVH
`define CONFIG_FUSE_DEFINES_SVH
`define WDT_POST_LSB 0
`define WDT_PRE_BIT 4
`define WDT_LOCKWAIT_BIT 5
`define WDT_WINOFF_BIT 6
`define WDT_WORD_RST 8'h7F
`define POR_DELAY_LSB 0
`define BOR_BIT 3
`define I2C1_BIT 4
`define I2C2_BIT 5
`define RST_WORD_RST 8'h3F
`define AUX_WRP_BIT 0
`define AUX_CP_BIT 1
`define AUX_KEY_LSB 2
`define AUX_WORD_RST 8'h03
`define AUX_WORD_ERASED 8'h03
`define PRE_RATIO_HI 8'h80
`define PRE_RATIO_LO 8'h20
`define POR_BASE_MS 2
`define CLK_KHZ 250000
`endif

// ==== common/config_fuse_pkg.sv ====
/*
  Types and the reset delay width shared by the configuration decoder and its bench.
  Assumes one clock domain.
*/
package config_fuse_pkg;
  localparam int POR_CYC_W = 25;

  typedef enum logic [0:0] {SW_IDLE, SW_WAIT} sw_state_t;

  typedef struct packed {
    logic [7:0] wdt_word;
    logic [7:0] rst_word;
    logic [7:0] aux_word;
    logic lockout;
    sw_state_t sw_state;
    logic switch_grant;
    logic window_mode;
    logic [7:0] pre_ratio;
    logic [15:0] post_ratio;
    logic lock_wait;
    logic por_en;
    logic [POR_CYC_W-1:0] por_cycles;
    logic bor_en;
    logic i2c1_alt;
    logic i2c2_alt;
    logic aux_cp;
    logic aux_wb;
    logic cfg_writable;
    logic prog_accept;
    logic prog_reject;
    logic cfg_rejected;
  } state_t;
endpackage : config_fuse_pkg

// ==== hdl/aux_protect_eval.sv ====
/*
  Judges the auxiliary key against the protect fields and whether the auxiliary word is open.
  Assumes the caller supplies both the stored and the next auxiliary word.
*/
`timescale 1ns/100ps
`include "config_fuse_defines.svh"
module aux_protect_eval (
  aux_protect_if.eval bus
);
  logic nxt_wrp_n;
  logic nxt_cp_n;
  logic [1:0] nxt_key;
  logic [1:0] expected_key;

  always_comb begin
    nxt_wrp_n = bus.aux_next[`AUX_WRP_BIT];
    nxt_cp_n = bus.aux_next[`AUX_CP_BIT];
    nxt_key = bus.aux_next[`AUX_KEY_LSB +: 2];
    expected_key = (nxt_wrp_n && nxt_cp_n) ? 2'h0 : 2'h3;
    bus.key_mismatch = (nxt_key != expected_key);
    bus.cfg_unlocked = bus.aux_cur[`AUX_WRP_BIT] && bus.aux_cur[`AUX_CP_BIT]
      && (bus.aux_cur[`AUX_KEY_LSB +: 2] == 2'h0) && bus.gen_code_protect_n
      && bus.gen_write_protect_n && (bus.gen_segment_key == 2'h0);
  end
endmodule : aux_protect_eval

// ==== hdl/config_fuse_decoder.sv ====
/*
  Decodes the watchdog, reset and auxiliary-segment configuration words into settings.
  Assumes all inputs synchronous to i_ref_clk; words arrive as one-cycle write strobes.
*/
`timescale 1ns/100ps
`include "config_fuse_defines.svh"
module config_fuse_decoder #(
  parameter int unsigned CLK_KHZ = `CLK_KHZ,
  parameter int unsigned POR_BASE_CYCLES = `POR_BASE_MS * CLK_KHZ
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_wdt_cfg_wr,
  input wire logic [7:0] i_wdt_cfg_data,
  input wire logic i_rst_cfg_wr,
  input wire logic [7:0] i_rst_cfg_data,
  input wire logic i_aux_cfg_wr,
  input wire logic [7:0] i_aux_cfg_data,
  input wire logic i_gen_code_protect_n,
  input wire logic i_gen_write_protect_n,
  input wire logic [1:0] i_gen_segment_key,
  input wire logic i_bulk_erase,
  input wire logic i_pll_switch_req,
  input wire logic i_pll_locked,
  input wire logic i_aux_prog_req,
  output logic o_wdt_window_mode,
  output logic [7:0] o_wdt_prescale_ratio,
  output logic [15:0] o_wdt_postscale_ratio,
  output logic o_lock_wait_enable,
  output logic o_switch_waiting,
  output logic o_switch_grant,
  output logic o_por_timer_enable,
  output logic [config_fuse_pkg::POR_CYC_W-1:0] o_por_delay_cycles,
  output logic o_brownout_enable,
  output logic o_i2c1_use_alt,
  output logic o_i2c2_use_alt,
  output logic o_aux_code_protected,
  output logic o_aux_write_blocked,
  output logic o_aux_key_lockout,
  output logic o_aux_cfg_writable,
  output logic o_aux_prog_accept,
  output logic o_aux_prog_reject,
  output logic o_aux_cfg_rejected
);
  localparam int PW = config_fuse_pkg::POR_CYC_W;

  if (POR_BASE_CYCLES == 0 || (64'(POR_BASE_CYCLES) << 6) >= (64'h1 << PW)) begin : g_chk
    $error("POR_BASE_CYCLES does not fit the reset delay output");
  end

  // Power of two for a small code
  function automatic logic [15:0] pow2(input logic [3:0] code);
    pow2 = 16'h0001 << code;
  endfunction : pow2

  // Reset timer length in cycles; zero when disabled
  function automatic logic [PW-1:0] por_len(input logic [2:0] code);
    logic [PW-1:0] base;
    base = PW'(POR_BASE_CYCLES);
    if (code == 3'h0) begin
      por_len = '0;
    end else begin
      por_len = base << (code - 3'h1);
    end
  endfunction : por_len

  config_fuse_pkg::state_t st_r;
  config_fuse_pkg::state_t st_nxt;
  aux_protect_if prot ();
  logic switch_ok;
  logic aux_open;
  logic [7:0] aux_word_nxt;

  aux_protect_eval u_eval (
    .bus(prot.eval)
  );

  assign prot.aux_cur = st_r.aux_word;
  assign prot.gen_code_protect_n = i_gen_code_protect_n;
  assign prot.gen_write_protect_n = i_gen_write_protect_n;
  assign prot.gen_segment_key = i_gen_segment_key;
  // Next auxiliary word kept outside the state copy so the key check forms no loop
  assign aux_word_nxt = i_bulk_erase ? `AUX_WORD_ERASED
    : (i_aux_cfg_wr && aux_open) ? i_aux_cfg_data : st_r.aux_word;
  assign prot.aux_next = aux_word_nxt;
  assign aux_open = prot.cfg_unlocked && !st_r.lockout;
  assign switch_ok = !st_r.lock_wait || i_pll_locked;

  always_comb begin
    st_nxt = st_r;
    // Word storage; new value decoded in the same step
    if (i_wdt_cfg_wr) begin
      st_nxt.wdt_word = i_wdt_cfg_data;
    end
    if (i_rst_cfg_wr) begin
      st_nxt.rst_word = i_rst_cfg_data;
    end
    st_nxt.cfg_rejected = 1'b0;
    st_nxt.aux_word = aux_word_nxt;
    if (i_aux_cfg_wr && !aux_open && !i_bulk_erase) begin
      st_nxt.cfg_rejected = 1'b1;
    end
    // Lockout is set by a mismatch and only erase clears it; set wins
    st_nxt.lockout = prot.key_mismatch || (st_r.lockout && !i_bulk_erase);
    // Watchdog
    st_nxt.window_mode = !st_nxt.wdt_word[`WDT_WINOFF_BIT];
    st_nxt.pre_ratio = st_nxt.wdt_word[`WDT_PRE_BIT] ? `PRE_RATIO_HI
      : `PRE_RATIO_LO;
    st_nxt.post_ratio = pow2(st_nxt.wdt_word[`WDT_POST_LSB +: 4]);
    st_nxt.lock_wait = st_nxt.wdt_word[`WDT_LOCKWAIT_BIT];
    // Reset word
    st_nxt.por_en = (st_nxt.rst_word[`POR_DELAY_LSB +: 3] != 3'h0);
    st_nxt.por_cycles = por_len(st_nxt.rst_word[`POR_DELAY_LSB +: 3]);
    st_nxt.bor_en = st_nxt.rst_word[`BOR_BIT];
    st_nxt.i2c1_alt = !st_nxt.rst_word[`I2C1_BIT];
    st_nxt.i2c2_alt = !st_nxt.rst_word[`I2C2_BIT];
    // Auxiliary segment
    st_nxt.aux_cp = !st_nxt.aux_word[`AUX_CP_BIT] || st_nxt.lockout;
    st_nxt.aux_wb = !st_nxt.aux_word[`AUX_WRP_BIT];
    st_nxt.cfg_writable = aux_open;
    st_nxt.prog_accept = i_aux_prog_req && !st_r.aux_wb;
    st_nxt.prog_reject = i_aux_prog_req && st_r.aux_wb;
    // Clock switch gate
    st_nxt.switch_grant = 1'b0;
    case (st_r.sw_state)
      config_fuse_pkg::SW_IDLE: begin
        if (i_pll_switch_req && switch_ok) begin
          st_nxt.switch_grant = 1'b1;
        end else if (i_pll_switch_req) begin
          st_nxt.sw_state = config_fuse_pkg::SW_WAIT;
        end
      end
      config_fuse_pkg::SW_WAIT: begin
        if (switch_ok) begin
          st_nxt.switch_grant = 1'b1;
          st_nxt.sw_state = config_fuse_pkg::SW_IDLE;
        end
      end
      default: begin
        st_nxt.sw_state = config_fuse_pkg::SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_r.wdt_word <= `WDT_WORD_RST;
      st_r.rst_word <= `RST_WORD_RST;
      st_r.aux_word <= `AUX_WORD_RST;
      st_r.lockout <= 1'b0;
      st_r.sw_state <= config_fuse_pkg::SW_IDLE;
      st_r.switch_grant <= 1'b0;
      st_r.window_mode <= 1'b0;
      st_r.pre_ratio <= `PRE_RATIO_HI;
      st_r.post_ratio <= 16'h8000;
      st_r.lock_wait <= 1'b1;
      st_r.por_en <= 1'b1;
      st_r.por_cycles <= PW'(POR_BASE_CYCLES) << 6;
      st_r.bor_en <= 1'b1;
      st_r.i2c1_alt <= 1'b0;
      st_r.i2c2_alt <= 1'b0;
      st_r.aux_cp <= 1'b0;
      st_r.aux_wb <= 1'b0;
      st_r.cfg_writable <= 1'b0;
      st_r.prog_accept <= 1'b0;
      st_r.prog_reject <= 1'b0;
      st_r.cfg_rejected <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign o_wdt_window_mode = st_r.window_mode;
  assign o_wdt_prescale_ratio = st_r.pre_ratio;
  assign o_wdt_postscale_ratio = st_r.post_ratio;
  assign o_lock_wait_enable = st_r.lock_wait;
  assign o_switch_waiting = (st_r.sw_state == config_fuse_pkg::SW_WAIT);
  assign o_switch_grant = st_r.switch_grant;
  assign o_por_timer_enable = st_r.por_en;
  assign o_por_delay_cycles = st_r.por_cycles;
  assign o_brownout_enable = st_r.bor_en;
  assign o_i2c1_use_alt = st_r.i2c1_alt;
  assign o_i2c2_use_alt = st_r.i2c2_alt;
  assign o_aux_code_protected = st_r.aux_cp;
  assign o_aux_write_blocked = st_r.aux_wb;
  assign o_aux_key_lockout = st_r.lockout;
  assign o_aux_cfg_writable = st_r.cfg_writable;
  assign o_aux_prog_accept = st_r.prog_accept;
  assign o_aux_prog_reject = st_r.prog_reject;
  assign o_aux_cfg_rejected = st_r.cfg_rejected;

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_window_mode;
    i_wdt_cfg_wr |=> o_wdt_window_mode == !$past(i_wdt_cfg_data[`WDT_WINOFF_BIT]);
  endproperty
  a_window_mode: assert property (p_window_mode)
    else $error("window mode does not follow written field");

  property p_lock_wait;
    o_switch_grant |-> ($past(!o_lock_wait_enable) || $past(i_pll_locked));
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("clock switch granted without lock");

  property p_no_stall;
    (i_pll_switch_req && !o_lock_wait_enable && !o_switch_waiting) |=> o_switch_grant;
  endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("switch delayed while lock wait off");

  property p_prescale;
    i_wdt_cfg_wr |=> o_wdt_prescale_ratio ==
      ($past(i_wdt_cfg_data[`WDT_PRE_BIT]) ? 8'h80 : 8'h20);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescale ratio wrong");

  property p_postscale;
    i_wdt_cfg_wr |=> o_wdt_postscale_ratio ==
      (16'h0001 << $past(i_wdt_cfg_data[`WDT_POST_LSB +: 4]));
  endproperty
  a_postscale: assert property (p_postscale)
    else $error("postscale ratio wrong");

  property p_por_delay;
    i_rst_cfg_wr |=> (o_por_timer_enable == ($past(i_rst_cfg_data[2:0]) != 3'h0))
      && (o_por_delay_cycles == (($past(i_rst_cfg_data[2:0]) == 3'h0) ? PW'(0)
      : (PW'(POR_BASE_CYCLES) << ($past(i_rst_cfg_data[2:0]) - 3'h1))));
  endproperty
  a_por_delay: assert property (p_por_delay)
    else $error("reset timer setting wrong");

  property p_brownout;
    i_rst_cfg_wr |=> o_brownout_enable == $past(i_rst_cfg_data[`BOR_BIT]);
  endproperty
  a_brownout: assert property (p_brownout)
    else $error("brown-out enable wrong");

  property p_lock_hold;
    (o_aux_key_lockout && !i_bulk_erase) |=> o_aux_key_lockout && o_aux_code_protected;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lockout released without erase");

  property p_code_protect;
    (i_aux_cfg_wr && aux_open && !i_bulk_erase) |=> o_aux_code_protected ==
      (!$past(i_aux_cfg_data[`AUX_CP_BIT]) || o_aux_key_lockout);
  endproperty
  a_code_protect: assert property (p_code_protect)
    else $error("code protect does not follow field");

  property p_prog_reject;
    (i_aux_prog_req && o_aux_write_blocked) |=> o_aux_prog_reject && !o_aux_prog_accept;
  endproperty
  a_prog_reject: assert property (p_prog_reject)
    else $error("protected write accepted");

  property p_cfg_locked;
    (i_aux_cfg_wr && !i_bulk_erase && !aux_open) |=> $stable(st_r.aux_word)
      && o_aux_cfg_rejected;
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("auxiliary word changed while protected");

  property p_i2c_pins;
    i_rst_cfg_wr |=> (o_i2c2_use_alt == !$past(i_rst_cfg_data[`I2C2_BIT]))
      && (o_i2c1_use_alt == !$past(i_rst_cfg_data[`I2C1_BIT]));
  endproperty
  a_i2c_pins: assert property (p_i2c_pins)
    else $error("pin choice wrong");

  property p_stable;
    !i_wdt_cfg_wr |=> $stable(o_wdt_postscale_ratio) && $stable(o_wdt_window_mode);
  endproperty
  a_stable: assert property (p_stable)
    else $error("watchdog setting moved without a write");

  property p_lock_wait_out;
    i_wdt_cfg_wr |=> o_lock_wait_enable == $past(i_wdt_cfg_data[`WDT_LOCKWAIT_BIT]);
  endproperty
  a_lock_wait_out: assert property (p_lock_wait_out)
    else $error("lock wait setting does not follow written field");

  property p_aux_wb;
    (i_aux_cfg_wr && aux_open && !i_bulk_erase) |=> o_aux_write_blocked ==
      !$past(i_aux_cfg_data[`AUX_WRP_BIT]);
  endproperty
  a_aux_wb: assert property (p_aux_wb)
    else $error("write block does not follow written field");

  property p_prog_accept;
    (i_aux_prog_req && !o_aux_write_blocked) |=> o_aux_prog_accept && !o_aux_prog_reject;
  endproperty
  a_prog_accept: assert property (p_prog_accept)
    else $error("unprotected write refused");

  property p_lockout_set;
    (i_aux_cfg_wr && aux_open && !i_bulk_erase && (i_aux_cfg_data[`AUX_KEY_LSB +: 2]
      != ((i_aux_cfg_data[`AUX_WRP_BIT] && i_aux_cfg_data[`AUX_CP_BIT]) ? 2'h0 : 2'h3)))
      |=> o_aux_key_lockout && o_aux_code_protected;
  endproperty
  a_lockout_set: assert property (p_lockout_set)
    else $error("key mismatch did not lock the auxiliary segment");

  property p_erase;
    i_bulk_erase |=> !o_aux_key_lockout && !o_aux_code_protected && !o_aux_write_blocked;
  endproperty
  a_erase: assert property (p_erase)
    else $error("bulk erase did not unlock the auxiliary segment");

  c_wait_grant: cover property (o_switch_waiting ##[1:20] o_switch_grant);
  c_lockout: cover property (!o_aux_key_lockout ##1 o_aux_key_lockout);
  c_erase_unlock: cover property (o_aux_key_lockout ##1 i_bulk_erase ##2 !o_aux_key_lockout);
  c_prog_reject: cover property (o_aux_prog_reject);
endmodule : config_fuse_decoder
